// [rtl/commutation_pkg.sv]
package commutation_pkg;

  // ------------------------------------------------------------------
  // sectors and switch pattern
  // ------------------------------------------------------------------
  localparam logic [2:0] SECTOR_NONE  = 3'h0;
  localparam logic [2:0] SECTOR_FIRST = 3'h1;
  localparam logic [2:0] SECTOR_LAST  = 3'h6;
  localparam int         SECTOR_COUNT = 6;
  localparam int         SECTOR_WIDTH_DEG = 60;
  localparam int         FULL_TURN_DEG    = 360;
  // first sector spans 330 deg through 30 deg
  localparam int         SECTOR1_START_DEG = 330;

  // switch vector order: {a_hi, b_hi, c_hi, a_lo, b_lo, c_lo}
  localparam logic [5:0] SW_OPEN = 6'h00;
  localparam logic [5:0] SW_S1   = 6'h22; // a high, b low
  localparam logic [5:0] SW_S2   = 6'h21; // a high, c low
  localparam logic [5:0] SW_S3   = 6'h11; // b high, c low
  localparam logic [5:0] SW_S4   = 6'h14; // b high, a low
  localparam logic [5:0] SW_S5   = 6'h0c; // c high, a low
  localparam logic [5:0] SW_S6   = 6'h0a; // c high, b low

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int         INTERVAL_WIDTH = 24;
  localparam int         SPEED_WIDTH    = 16;
  localparam int         DUTY_WIDTH     = 12;
  localparam int         POLE_WIDTH     = 4;
  localparam int         GAIN_WIDTH     = 8;
  localparam int         DUTY_SHIFT     = 8;
  localparam logic [3:0] POLE_PAIRS_RST = 4'h1;

  // speed scale: clock 40 MHz, speed reported in revolutions per minute
  localparam int         CLOCK_HZ       = 40000000;
  localparam int         SEC_PER_MIN    = 60;
  localparam longint     SPEED_NUMER    = longint'(CLOCK_HZ) * SEC_PER_MIN;

  // a divide takes one cycle per quotient bit
  localparam int         DIV_WIDTH      = 32;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_RUN  = 3'b010,
    DIV_DONE = 3'b100
  } div_state_t;

endpackage : commutation_pkg

// [rtl/speed_divider.sv]
`timescale 1ns/1ps
// serial restoring divider, one quotient bit per clock
module speed_divider #(
  parameter int WIDTH = commutation_pkg::DIV_WIDTH
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] dividend_in,
  input  wire logic [WIDTH-1:0] divisor_in,
  output logic                  done_out,
  output logic      [WIDTH-1:0] quotient_out
);

  typedef struct packed {
    commutation_pkg::div_state_t state;
    logic [WIDTH-1:0]            rem;
    logic [WIDTH-1:0]            quo;
    logic [WIDTH-1:0]            den;
    logic [5:0]                  cnt;
    logic                        done;
    logic [WIDTH-1:0]            result;
  } div_t;

  div_t div_reg;
  div_t div_next;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [WIDTH:0] trial;
    trial = '0;
    div_next = div_reg;
    div_next.done = 1'b0;
    case (div_reg.state)
      commutation_pkg::DIV_IDLE: begin
        if (start_in) begin
          div_next.rem   = '0;
          div_next.quo   = dividend_in;
          div_next.den   = divisor_in;
          div_next.cnt   = 6'(WIDTH);
          div_next.state = commutation_pkg::DIV_RUN;
        end
      end
      commutation_pkg::DIV_RUN: begin
        trial = {div_reg.rem, div_reg.quo[WIDTH-1]} - {1'b0, div_reg.den};
        if (!trial[WIDTH]) begin
          div_next.rem = trial[WIDTH-1:0];
          div_next.quo = {div_reg.quo[WIDTH-2:0], 1'b1};
        end else begin
          div_next.rem = {div_reg.rem[WIDTH-2:0], div_reg.quo[WIDTH-1]};
          div_next.quo = {div_reg.quo[WIDTH-2:0], 1'b0};
        end
        div_next.cnt = div_reg.cnt - 6'h01;
        if (div_reg.cnt == 6'h01) begin
          div_next.state = commutation_pkg::DIV_DONE;
        end
      end
      commutation_pkg::DIV_DONE: begin
        // a zero divisor saturates instead of returning garbage
        div_next.result = (div_reg.den == '0) ? '1 : div_reg.quo;
        div_next.done   = 1'b1;
        div_next.state  = commutation_pkg::DIV_IDLE;
      end
      default: begin
        div_next.state = commutation_pkg::DIV_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg       <= '0;
      div_reg.state <= commutation_pkg::DIV_IDLE;
    end else begin
      div_reg <= div_next;
    end
  end

  assign done_out     = div_reg.done;
  assign quotient_out = div_reg.result;

endmodule : speed_divider

// [rtl/six_step_commutation_speed.sv]
`timescale 1ns/1ps
module six_step_commutation_speed #(
  parameter int IW = commutation_pkg::INTERVAL_WIDTH,
  parameter int SW = commutation_pkg::SPEED_WIDTH,
  parameter int DW = commutation_pkg::DUTY_WIDTH,
  parameter int GW = commutation_pkg::GAIN_WIDTH
) (
  input  wire logic          mclk_in,
  input  wire logic          rst_n_in,
  input  wire logic          enable_in,
  input  wire logic          load_sector_in,
  input  wire logic [2:0]    start_sector_in,
  input  wire logic          commutate_in,
  input  wire logic [3:0]    pole_pairs_in,
  input  wire logic [SW-1:0] speed_request_in,
  input  wire logic [GW-1:0] prop_gain_in,
  input  wire logic [GW-1:0] integ_gain_in,
  output logic               phase_a_high_switch_out,
  output logic               phase_b_high_switch_out,
  output logic               phase_c_high_switch_out,
  output logic               phase_a_low_switch_out,
  output logic               phase_b_low_switch_out,
  output logic               phase_c_low_switch_out,
  output logic [2:0]         sector_out,
  output logic [IW-1:0]      commutation_interval_out,
  output logic [SW-1:0]      mech_speed_out,
  output logic               speed_valid_out,
  output logic [DW-1:0]      duty_out,
  output logic [8:0]         mech_angle_out
);

  localparam int DIVW = commutation_pkg::DIV_WIDTH;
  localparam int ACCW = SW + GW + 4;
  localparam int SUMW = IW + 3;

  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------
  // switch pattern for a sector; anything out of range opens all
  function automatic logic [5:0] sector_pattern(input logic [2:0] s);
    case (s)
      3'h1:    sector_pattern = commutation_pkg::SW_S1;
      3'h2:    sector_pattern = commutation_pkg::SW_S2;
      3'h3:    sector_pattern = commutation_pkg::SW_S3;
      3'h4:    sector_pattern = commutation_pkg::SW_S4;
      3'h5:    sector_pattern = commutation_pkg::SW_S5;
      3'h6:    sector_pattern = commutation_pkg::SW_S6;
      default: sector_pattern = commutation_pkg::SW_OPEN;
    endcase
  endfunction : sector_pattern

  // sector step with wrap from the last back to the first
  function automatic logic [2:0] next_sector(input logic [2:0] s);
    if (s == commutation_pkg::SECTOR_LAST || s == 3'h0) begin
      next_sector = commutation_pkg::SECTOR_FIRST;
    end else begin
      next_sector = s + 3'h1;
    end
  endfunction : next_sector

  // a sector number is usable only inside 1..6; 0 and 7 mean none
  function automatic logic sector_valid(input logic [2:0] s);
    sector_valid = (s >= commutation_pkg::SECTOR_FIRST) &&
                   (s <= commutation_pkg::SECTOR_LAST);
  endfunction : sector_valid

  // saturating clamp of a signed value into an unsigned field
  function automatic logic [DW-1:0] clamp_duty(
    input logic signed [ACCW-1:0] v
  );
    logic signed [ACCW-1:0] sh;
    sh = v >>> commutation_pkg::DUTY_SHIFT;
    if (sh < 0) begin
      clamp_duty = '0;
    end else if (sh > ACCW'((1 << DW) - 1)) begin
      clamp_duty = '1;
    end else begin
      clamp_duty = sh[DW-1:0];
    end
  endfunction : clamp_duty

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [2:0]              sector;
    logic [5:0]              sw;
    logic [IW-1:0]           timer;
    logic                    seen;
    logic [IW-1:0]           last_int;
    logic [5:0][IW-1:0]      ints;
    logic [2:0]              filled;
    logic                    div_start;
    logic [SW-1:0]           speed;
    logic                    speed_valid;
    logic signed [ACCW-1:0]  integ;
    logic [DW-1:0]           duty;
    logic [8:0]              mech_angle;
    logic [3:0]              poles;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic             div_done;
  logic [DIVW-1:0]  div_quot;
  logic [SUMW-1:0]  int_sum;
  logic [DIVW-1:0]  div_den;
  logic [DIVW-1:0]  div_num;

  // --------------------------------------------------------------
  // speed arithmetic
  // --------------------------------------------------------------
  // sum of the six sector intervals is one full electrical turn
  always_comb begin
    int_sum = '0;
    for (int i = 0; i < commutation_pkg::SECTOR_COUNT; i++) begin
      int_sum = int_sum + SUMW'(st_reg.ints[i]);
    end
  end

  // rpm = clocks per minute / (pole pairs * cycles per turn)
  // six saturated intervals times fifteen pole pairs still fit DIVW bits
  assign div_num = DIVW'(commutation_pkg::SPEED_NUMER);
  assign div_den = DIVW'(int_sum) * DIVW'(st_reg.poles);

  // a serial divide costs 35 cycles but little area; once a step is plenty
  speed_divider #(
    .WIDTH(DIVW)
  ) u_div (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .start_in     (st_reg.div_start),
    .dividend_in  (div_num),
    .divisor_in   (div_den),
    .done_out     (div_done),
    .quotient_out (div_quot)
  );

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic signed [ACCW-1:0] err;
    logic signed [ACCW-1:0] pterm;
    logic signed [ACCW-1:0] iterm;
    logic [2:0]             ns;
    logic [11:0]            eang;
    logic signed [ACCW-1:0] pi_sum;
    logic [DW-1:0]          duty_new;
    err   = '0;
    pterm = '0;
    iterm = '0;
    ns    = '0;
    eang  = '0;
    pi_sum   = '0;
    duty_new = '0;
    st_next = st_reg;
    st_next.div_start = 1'b0;
    // pole-pair count is caught each cycle; zero is treated as one
    st_next.poles = (pole_pairs_in == 4'h0) ?
                    commutation_pkg::POLE_PAIRS_RST : pole_pairs_in;

    // free-running interval timer, sticks at full scale when stalled
    // so a stopped rotor reads slow instead of wrapping to a short gap
    if (st_reg.timer != '1) begin
      st_next.timer = st_reg.timer + IW'(1);
    end

    if (!enable_in) begin
      // disabled: open bridge, forget position and speed history
      st_next.sector = commutation_pkg::SECTOR_NONE;
      st_next.sw     = commutation_pkg::SW_OPEN;
      st_next.seen   = 1'b0;
      st_next.filled = '0;
      st_next.integ  = '0;
    end else if (load_sector_in) begin
      // a sector must be chosen before anything conducts
      ns = sector_valid(start_sector_in) ? start_sector_in :
           commutation_pkg::SECTOR_NONE;
      st_next.sector = ns;
      st_next.sw     = sector_pattern(ns);
      st_next.timer  = '0;
      st_next.seen   = 1'b0;
      st_next.filled = '0;
    end else if (commutate_in && sector_valid(st_reg.sector)) begin
      // step to the next sector on each commutation event
      ns = next_sector(st_reg.sector);
      st_next.sector = ns;
      st_next.sw     = sector_pattern(ns);
      // restart at one so back-to-back events measure one cycle, not zero
      st_next.timer  = IW'(1);
      st_next.seen   = 1'b1;
      // first event only starts the timer; a partial gap is not a sixth
      if (st_reg.seen) begin
        st_next.last_int = st_reg.timer;
        st_next.ints[st_reg.sector - 3'h1] = st_reg.timer;
        if (st_reg.filled != 3'h6) begin
          st_next.filled = st_reg.filled + 3'h1;
        end
        if (st_reg.filled >= 3'h5) begin
          st_next.div_start = 1'b1;
        end
      end
    end

    // speed updates once all six sector intervals are known; a result
    // still in flight across a load or disable belongs to the old
    // history and is dropped, since the fill count has been cleared
    // limitation: a start is ignored while the divider is busy, so with
    // commutations closer than its latency the speed lags a few steps
    if (div_done && st_reg.filled == 3'h6) begin
      st_next.speed = (div_quot > DIVW'({SW{1'b1}})) ?
                      '1 : div_quot[SW-1:0];
      st_next.speed_valid = 1'b1;
    end
    if (!enable_in || load_sector_in) begin
      st_next.speed_valid = 1'b0;
      st_next.speed       = '0;
    end

    // PI speed loop, integrator frozen at duty limits (anti-windup)
    err   = ACCW'(speed_request_in) - ACCW'(st_reg.speed);
    pterm = err * ACCW'(prop_gain_in);
    iterm = st_reg.integ + err * ACCW'(integ_gain_in);
    pi_sum   = pterm + iterm;
    duty_new = clamp_duty(pi_sum);
    if (enable_in && sector_valid(st_reg.sector)) begin
      // the integrator moves only while the output is inside its range,
      // or when the error pulls it back off a limit; this keeps it from
      // winding up during a stall at full duty
      if (duty_new != '1 && duty_new != '0) begin
        st_next.integ = iterm;
      end else if (clamp_duty(st_reg.integ) == '0 && err > 0) begin
        st_next.integ = iterm;
      end else if (clamp_duty(st_reg.integ) == '1 && err < 0) begin
        st_next.integ = iterm;
      end
      st_next.duty = duty_new;
    end else begin
      st_next.duty = '0;
    end

    // mechanical angle: sector start angle over pole pairs, in degrees;
    // it moves in steps of 60/p degrees, any finer position has to be
    // interpolated outside from the interval timer
    if (!sector_valid(st_reg.sector)) begin
      st_next.mech_angle = '0;
    end else begin
      eang = 12'((commutation_pkg::SECTOR1_START_DEG +
             (int'(st_reg.sector) - 1) * commutation_pkg::SECTOR_WIDTH_DEG)
             % commutation_pkg::FULL_TURN_DEG);
      st_next.mech_angle = 9'(eang / 12'(st_reg.poles));
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  // reset opens every switch and clears all interval timers
  // the pole count leaves reset at one so the angle divide never sees zero
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg       <= '0;
      st_reg.poles <= commutation_pkg::POLE_PAIRS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // outputs, all straight from flops
  // --------------------------------------------------------------
  // nothing is decoded after the flops, so the bridge sees no glitch
  // while the sector changes
  assign phase_a_high_switch_out  = st_reg.sw[5];
  assign phase_b_high_switch_out  = st_reg.sw[4];
  assign phase_c_high_switch_out  = st_reg.sw[3];
  assign phase_a_low_switch_out   = st_reg.sw[2];
  assign phase_b_low_switch_out   = st_reg.sw[1];
  assign phase_c_low_switch_out   = st_reg.sw[0];
  assign sector_out               = st_reg.sector;
  assign commutation_interval_out = st_reg.last_int;
  assign mech_speed_out           = st_reg.speed;
  assign speed_valid_out          = st_reg.speed_valid;
  assign duty_out                 = st_reg.duty;
  assign mech_angle_out           = st_reg.mech_angle;

endmodule : six_step_commutation_speed

// [bench/six_step_commutation_speed_assertions.sv]
`timescale 1ns/1ps
module six_step_commutation_speed_assertions #(
  parameter int DW = 12
) (
  input wire logic          mclk_in,
  input wire logic          rst_n_in,
  input wire logic          enable_in,
  input wire logic          load_sector_in,
  input wire logic [2:0]    start_sector_in,
  input wire logic          commutate_in,
  input wire logic          phase_a_high_switch_out,
  input wire logic          phase_b_high_switch_out,
  input wire logic          phase_c_high_switch_out,
  input wire logic          phase_a_low_switch_out,
  input wire logic          phase_b_low_switch_out,
  input wire logic          phase_c_low_switch_out,
  input wire logic [2:0]    sector_out,
  input wire logic [DW-1:0] duty_out
);
  // ----
  // helpers
  // ----
  logic [5:0] sw;
  logic [5:0] pat;
  assign sw = {phase_a_high_switch_out, phase_b_high_switch_out,
               phase_c_high_switch_out, phase_a_low_switch_out,
               phase_b_low_switch_out, phase_c_low_switch_out};
  // expected pattern; anything outside 1..6 must leave the bridge open
  always_comb begin
    case (sector_out)
      3'h1:    pat = 6'h22;
      3'h2:    pat = 6'h21;
      3'h3:    pat = 6'h11;
      3'h4:    pat = 6'h14;
      3'h5:    pat = 6'h0c;
      3'h6:    pat = 6'h0a;
      default: pat = 6'h00;
    endcase
  end
  function automatic logic [2:0] adv(input logic [2:0] s);
    return (s == 3'h6) ? 3'h1 : s + 3'h1;
  endfunction : adv
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence comm_taken;
    enable_in && commutate_in && !load_sector_in && sector_out != 3'h0;
  endsequence
  sequence two_steps;
    comm_taken ##1 comm_taken;
  endsequence
  // ----
  // properties
  // ----
  sector_pattern_a: assert property (sw == pat)
    else $error("switch pattern does not match sector");
  phase_exclusive_a: assert property (sector_out != 3'h0 |->
    $onehot(sw[5:3]) && $onehot(sw[2:0]) && (sw[5:3] & sw[2:0]) == 3'h0)
    else $error("phase pair not one top and one bottom");
  step_order_a: assert property (comm_taken |=>
    sector_out == adv($past(sector_out)))
    else $error("sector did not step upward");
  two_steps_a: assert property (two_steps |=>
    sector_out == adv(adv($past(sector_out, 2))))
    else $error("back to back steps lost");
  load_sector_a: assert property (enable_in && load_sector_in |=>
    sector_out == (($past(start_sector_in) inside {[3'h1:3'h6]}) ?
    $past(start_sector_in) : 3'h0))
    else $error("loaded sector wrong");
  idle_ignore_a: assert property (enable_in && !load_sector_in &&
    sector_out == 3'h0 |=> sector_out == 3'h0)
    else $error("sector chosen without load");
  disable_open_a: assert property (!enable_in |=>
    sector_out == 3'h0 && sw == 6'h00 && duty_out == '0)
    else $error("disable left bridge driven");
  hold_switches_a: assert property ($changed(sw) |->
    $past(!enable_in || load_sector_in || commutate_in))
    else $error("switches moved without event");
endmodule : six_step_commutation_speed_assertions

bind six_step_commutation_speed six_step_commutation_speed_assertions #(
  .DW(DW)
) u_checker (
  .mclk_in                 (mclk_in),
  .rst_n_in                (rst_n_in),
  .enable_in               (enable_in),
  .load_sector_in          (load_sector_in),
  .start_sector_in         (start_sector_in),
  .commutate_in            (commutate_in),
  .phase_a_high_switch_out (phase_a_high_switch_out),
  .phase_b_high_switch_out (phase_b_high_switch_out),
  .phase_c_high_switch_out (phase_c_high_switch_out),
  .phase_a_low_switch_out  (phase_a_low_switch_out),
  .phase_b_low_switch_out  (phase_b_low_switch_out),
  .phase_c_low_switch_out  (phase_c_low_switch_out),
  .sector_out              (sector_out),
  .duty_out                (duty_out)
);

// [bench/inverter_model.sv]
`timescale 1ns/1ps
// ----
// ideal bridge: per phase current code {sink, source}
// ----
module inverter_model (
  input  wire logic [5:0] switches_in,
  output logic      [1:0] current_a_out,
  output logic      [1:0] current_b_out,
  output logic      [1:0] current_c_out
);
  // top closed sources current, bottom closed sinks it, 2'h3 is a short
  // across the supply; the ideal model does not protect itself from it
  assign current_a_out = {switches_in[2], switches_in[5]};
  assign current_b_out = {switches_in[1], switches_in[4]};
  assign current_c_out = {switches_in[0], switches_in[3]};
endmodule : inverter_model

// [bench/tb_six_step_commutation_speed.sv]
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); \
  end \
end
module tb_six_step_commutation_speed;
  logic        mclk_in, rst_n_in, enable_in, load_sector_in, commutate_in;
  logic [2:0]  start_sector_in, sector_out;
  logic [3:0]  pole_pairs_in;
  logic [15:0] speed_request_in, mech_speed;
  logic [7:0]  prop_gain_in, integ_gain_in;
  logic [5:0]  sw;
  logic [23:0] interval;
  logic        speed_valid;
  logic [11:0] duty;
  logic [8:0]  angle;
  logic [1:0]  cur_a, cur_b, cur_c;
  int          errors, n_compared, cur, last, stored, dexp;
  int          slot [1:6];
  // ----
  // reference tables, index is the sector
  // ----
  localparam logic [5:0] PAT [7] = '{6'h00, 6'h22, 6'h21, 6'h11, 6'h14,
                                     6'h0c, 6'h0a};
  localparam logic [5:0] CUR [7] = '{6'h00, 6'h18, 6'h12, 6'h06, 6'h24,
                                     6'h21, 6'h09};
  localparam int         ANG [7] = '{0, 330, 30, 90, 150, 210, 270};
  six_step_commutation_speed u_six_step_commutation_speed (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
    .load_sector_in(load_sector_in), .start_sector_in(start_sector_in),
    .commutate_in(commutate_in), .pole_pairs_in(pole_pairs_in),
    .speed_request_in(speed_request_in), .prop_gain_in(prop_gain_in),
    .integ_gain_in(integ_gain_in),
    .phase_a_high_switch_out(sw[5]), .phase_b_high_switch_out(sw[4]),
    .phase_c_high_switch_out(sw[3]), .phase_a_low_switch_out(sw[2]),
    .phase_b_low_switch_out(sw[1]), .phase_c_low_switch_out(sw[0]),
    .sector_out(sector_out), .commutation_interval_out(interval),
    .mech_speed_out(mech_speed), .speed_valid_out(speed_valid),
    .duty_out(duty), .mech_angle_out(angle));
  inverter_model u_inverter_model (.switches_in(sw), .current_a_out(cur_a),
    .current_b_out(cur_b), .current_c_out(cur_c));
  // ----
  // tasks
  // ----
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  function automatic int poles();
    return (pole_pairs_in == 4'h0) ? 1 : int'(pole_pairs_in);
  endfunction : poles
  task automatic check_out(int s);
    `CHECK("sector", 3'(s), sector_out)
    `CHECK("switches", PAT[s], sw)
    `CHECK("currents", CUR[s], {cur_a, cur_b, cur_c})
    if (s != 0) `CHECK("angle", 9'(ANG[s] / poles()), angle)
  endtask : check_out
  // n commutation cycles in a row, then idle until gap cycles have gone
  task automatic pulse(logic ld, int n, int gap);
    load_sector_in = ld;
    commutate_in = (n > 0);
    repeat ((n > 0) ? n : 1) @(negedge mclk_in);
    load_sector_in = 1'b0;
    commutate_in = 1'b0;
    repeat (gap - ((n > 1) ? n : 1)) @(negedge mclk_in);
  endtask : pulse
  task automatic step(int gap);
    longint e;
    int     sum;
    pulse(1'b0, 1, 3);
    if (last > 0) begin
      slot[cur] = last;
      stored++;
      `CHECK("interval", 24'(last), interval)
    end
    cur = (cur == 6) ? 1 : cur + 1;
    check_out(cur);
    last = gap;
    if (stored >= 6) begin
      // result is due 35 cycles after the step, checked with some slack
      repeat (47) @(negedge mclk_in);
      sum = 0;
      foreach (slot[i]) sum += slot[i];
      e = 64'd2400000000 / (poles() * sum);
      if (e > 65535) e = 65535;
      `CHECK("speed_valid", 1'b1, speed_valid)
      `CHECK("speed", 16'(e), mech_speed)
      repeat (gap - 50) @(negedge mclk_in);
    end else repeat (gap - 3) @(negedge mclk_in);
  endtask : step
  // ----
  // clock, watchdog, main sequence
  // ----
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    #(25 * 60000);
    errors++;
    end_of_test();
  end
  initial begin
    {rst_n_in, enable_in, load_sector_in, commutate_in} = 4'h0;
    {start_sector_in, pole_pairs_in, speed_request_in} = '0;
    {prop_gain_in, integ_gain_in} = '0;
    {errors, n_compared, last, stored} = '0;
    void'($urandom(32'ha53d6387));
    repeat (6) @(negedge mclk_in);
    rst_n_in = 1'b1;
    check_out(0);
    `CHECK("duty", 12'h000, duty)
    speed_request_in = 16'($urandom_range(1000, 30000));
    prop_gain_in = 8'($urandom);
    integ_gain_in = 8'($urandom);
    enable_in = 1'b1;
    pulse(1'b0, 1, 3);
    check_out(0);
    start_sector_in = 3'h1;
    pulse(1'b1, 0, 3);
    cur = 1;
    check_out(1);
    // random spacing and pole count over more than one turn
    for (int k = 0; k < 9; k++) begin
      pole_pairs_in = 4'($urandom_range(0, 4));
      step($urandom_range(3000, 4000));
    end
    start_sector_in = 3'h4;
    pulse(1'b1, 1, 3);
    check_out(4);
    pulse(1'b0, 2, 4);
    check_out(6);
    start_sector_in = 3'h7;
    pulse(1'b1, 0, 3);
    check_out(0);
    start_sector_in = 3'h2;
    pulse(1'b1, 0, 3);
    check_out(2);
    enable_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    check_out(0);
    `CHECK("duty", 12'h000, duty)
    `CHECK("speed", 16'h0000, mech_speed)
    // integrator cleared by the disable and held at zero, so duty is the
    // proportional part alone on the full request
    integ_gain_in = 8'h00;
    enable_in = 1'b1;
    start_sector_in = 3'h5;
    pulse(1'b1, 0, 3);
    check_out(5);
    dexp = (int'(speed_request_in) * int'(prop_gain_in)) >> 8;
    if (dexp > 4095) dexp = 4095;
    `CHECK("duty", 12'(dexp), duty)
    pulse(1'b0, 1, 40);
    rst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    check_out(0);
    `CHECK("interval", 24'h000000, interval)
    rst_n_in = 1'b1;
    // after a mid-run reset the sector stays empty until a load
    pulse(1'b0, 1, 3);
    check_out(0);
    start_sector_in = 3'h3;
    pulse(1'b1, 0, 3);
    check_out(3);
    end_of_test();
  end
endmodule : tb_six_step_commutation_speed
